// >>> src/tsic_irq_ctrl.sv
// Purpose: Two-source interrupt controller with return-stack gating
// Assumes: Core gives phase-two, call, return and halt strobes on core_clk
// Notes: Register reached over Avalon-MM, one-cycle waitrequest
module tsic_irq_ctrl
  import tsic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Sources
  input wire logic extIrq_n,
  input wire logic timerOverflow,
  // Core sequencer
  input wire logic phaseTwoPulse,
  input wire logic subCall,
  input wire logic subroutineExit,
  input wire logic irqExitReenable,
  input wire logic haltEnter,
  input wire logic [9:0] pcValue,
  // Answers to core
  output logic irqAck,
  output logic [9:0] irqVector,
  output logic [9:0] returnAddr,
  output logic wakeUp,
  output logic stackFull
);
  typedef struct packed
  {
    tsic_state_t fsm;
    logic gie;
    logic eie;
    logic tie;
    logic exf;
    logic tmf;
    logic [1:0] stackIndex;
    logic [9:0] stk0;
    logic [9:0] stk1;
    logic ack;
    logic [9:0] vec;
    logic [9:0] retAddr;
    logic wake;
    logic exfAtHalt;
    logic tmfAtHalt;
    logic busy;
    logic [31:0] rdata;
  } tsic_st_t;

  tsic_st_t st_ff;
  tsic_st_t nxt_st;
  tsic_sync_if syncBus();

  logic busSel;
  logic ctrlHit;
  logic statHit;
  logic full;
  logic extReq;
  logic tmrReq;
  logic [7:0] ctrlView;

  // Packs the control register image
  function automatic logic [7:0] ctrl_image(input tsic_st_t s);
    logic [7:0] v;
    v = 8'h00;
    v[TSIC_BIT_GIE] = s.gie;
    v[TSIC_BIT_EIE] = s.eie;
    v[TSIC_BIT_TIE] = s.tie;
    v[TSIC_BIT_EXF] = s.exf;
    v[TSIC_BIT_TMF] = s.tmf;
    return v & TSIC_CTRL_MASK;
  endfunction : ctrl_image

  tsic_pin_sync u_sync
  (
    .core_clk(core_clk),
    .nrst(nrst),
    .extIrq_n(extIrq_n),
    .sync(syncBus)
  );

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  assign full = (st_ff.stackIndex == 2'(TSIC_STACK_DEPTH));
  assign extReq = st_ff.gie & st_ff.eie & st_ff.exf & ~full;
  assign tmrReq = st_ff.gie & st_ff.tie & st_ff.tmf & ~full;
  assign ctrlView = ctrl_image(st_ff);
  assign busSel = avs_read | avs_write;
  assign ctrlHit = (avs_address == TSIC_CTRL_OFS);
  assign statHit = (avs_address == TSIC_STAT_OFS);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.wake = 1'b0;
    // One wait cycle per access, then the answer edge
    nxt_st.busy = busSel & ~st_ff.busy;
    if (busSel && !st_ff.busy)
    begin
      nxt_st.rdata = 32'h0000_0000;
      if (avs_read && ctrlHit)
      begin
        nxt_st.rdata = {24'h00_0000, ctrlView};
      end
      else if (avs_read && statHit)
      begin
        nxt_st.rdata = {28'h000_0000, 1'b0, full, st_ff.stackIndex};
      end
    end
    // Software write first, so hardware events below win
    if (avs_write && st_ff.busy && ctrlHit && avs_byteenable[0])
    begin
      nxt_st.gie = avs_writedata[TSIC_BIT_GIE];
      nxt_st.eie = avs_writedata[TSIC_BIT_EIE];
      nxt_st.tie = avs_writedata[TSIC_BIT_TIE];
      nxt_st.exf = avs_writedata[TSIC_BIT_EXF];
      nxt_st.tmf = avs_writedata[TSIC_BIT_TMF];
    end
    // Stack movement by core calls and returns
    if (subCall)
    begin
      nxt_st.stk1 = st_ff.stk0;
      nxt_st.stk0 = pcValue;
      if (!full)
      begin
        nxt_st.stackIndex = st_ff.stackIndex + 2'h1;
      end
    end
    else if ((subroutineExit || irqExitReenable) && st_ff.stackIndex != 2'h0)
    begin
      nxt_st.retAddr = st_ff.stk0;
      nxt_st.stk0 = st_ff.stk1;
      nxt_st.stackIndex = st_ff.stackIndex - 2'h1;
    end
    if (irqExitReenable)
    begin
      nxt_st.gie = 1'b1;
    end
    case (st_ff.fsm)
      TSIC_IDLE:
      begin
        if (haltEnter)
        begin
          nxt_st.fsm = TSIC_HALT;
          nxt_st.exfAtHalt = st_ff.exf;
          nxt_st.tmfAtHalt = st_ff.tmf;
        end
        // Let a pop settle first; taking both at once would lose it
        else if (phaseTwoPulse && !subCall && !subroutineExit && !irqExitReenable
          && (extReq || tmrReq))
        begin
          nxt_st.fsm = TSIC_ACK;
          nxt_st.ack = 1'b1;
          nxt_st.gie = 1'b0;
          nxt_st.stk1 = st_ff.stk0;
          nxt_st.stk0 = pcValue;
          nxt_st.stackIndex = st_ff.stackIndex + 2'h1;
          if (extReq)
          begin
            nxt_st.vec = TSIC_VEC_EXT;
            nxt_st.exf = 1'b0;
          end
          else
          begin
            nxt_st.vec = TSIC_VEC_TMR;
            nxt_st.tmf = 1'b0;
          end
        end
      end
      TSIC_HALT:
      begin
        if ((st_ff.exf && !st_ff.exfAtHalt) || (st_ff.tmf && !st_ff.tmfAtHalt))
        begin
          nxt_st.fsm = TSIC_IDLE;
          nxt_st.wake = 1'b1;
        end
      end
      TSIC_ACK:
      begin
        nxt_st.fsm = TSIC_IDLE;
      end
      default:
      begin
        nxt_st.fsm = TSIC_IDLE;
      end
    endcase
    // Events last: a set beats a same-cycle clear
    if (syncBus.fallPulse)
    begin
      nxt_st.exf = 1'b1;
    end
    if (timerOverflow)
    begin
      nxt_st.tmf = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_waitrequest = busSel & ~st_ff.busy;
  assign avs_readdata = st_ff.rdata;
  assign irqAck = st_ff.ack;
  assign irqVector = st_ff.vec;
  assign returnAddr = st_ff.retAddr;
  assign wakeUp = st_ff.wake;
  assign stackFull = full;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_fall_sets_ext;
    @(posedge core_clk) disable iff (!nrst)
    syncBus.fallPulse |=> st_ff.exf;
  endproperty
  a_fall_sets_ext: assert property (p_fall_sets_ext) else $error("edge lost");

  property p_ovf_sets_tmr;
    @(posedge core_clk) disable iff (!nrst)
    timerOverflow |=> st_ff.tmf;
  endproperty
  a_ovf_sets_tmr: assert property (p_ovf_sets_tmr) else $error("overflow lost");

  property p_ext_vector;
    @(posedge core_clk) disable iff (!nrst)
    (st_ff.fsm == TSIC_IDLE && !haltEnter && !subCall && phaseTwoPulse && extReq
      && !subroutineExit && !irqExitReenable)
      |=> irqAck && irqVector == 10'h004 && !st_ff.gie;
  endproperty
  a_ext_vector: assert property (p_ext_vector) else $error("ext vector bad");

  property p_tmr_vector;
    @(posedge core_clk) disable iff (!nrst)
    (irqAck && irqVector == 10'h008) |-> $past(st_ff.tmf) && !$past(extReq);
  endproperty
  a_tmr_vector: assert property (p_tmr_vector) else $error("timer vector bad");

  property p_no_ack_full;
    @(posedge core_clk) disable iff (!nrst)
    irqAck |-> $past(st_ff.stackIndex) < 2'h2;
  endproperty
  a_no_ack_full: assert property (p_no_ack_full) else $error("ack on full");

  property p_push_pc;
    @(posedge core_clk) disable iff (!nrst)
    irqAck |-> st_ff.stk0 == $past(pcValue) && st_ff.stackIndex == $past(st_ff.stackIndex) + 2'h1;
  endproperty
  a_push_pc: assert property (p_push_pc) else $error("push wrong");

  property p_irq_exit_reenable_gie;
    @(posedge core_clk) disable iff (!nrst)
    irqExitReenable |=> st_ff.gie;
  endproperty
  a_irq_exit_reenable_gie: assert property (p_irq_exit_reenable_gie) else $error("irq_exit_reenable no enable");

  property p_unused_zero;
    @(posedge core_clk) disable iff (!nrst)
    (ctrlView & 8'hC8) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

  property p_no_wake_stale;
    @(posedge core_clk) disable iff (!nrst)
    wakeUp |-> ($past(st_ff.exf) && !$past(st_ff.exfAtHalt))
      || ($past(st_ff.tmf) && !$past(st_ff.tmfAtHalt));
  endproperty
  a_no_wake_stale: assert property (p_no_wake_stale) else $error("stale wake");

  property p_halt_wake;
    @(posedge core_clk) disable iff (!nrst)
    st_ff.fsm == TSIC_HALT
      && ((st_ff.exf && !st_ff.exfAtHalt) || (st_ff.tmf && !st_ff.tmfAtHalt))
      |=> wakeUp && st_ff.fsm == TSIC_IDLE;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("no wake");

  property p_ret_keeps_gie;
    @(posedge core_clk) disable iff (!nrst)
    subroutineExit && !irqExitReenable && !(avs_write && st_ff.busy && ctrlHit)
      |=> st_ff.gie == $past(st_ff.gie);
  endproperty
  a_ret_keeps_gie: assert property (p_ret_keeps_gie) else $error("return moved enable");

  property p_ext_flag_holds;
    @(posedge core_clk) disable iff (!nrst)
    st_ff.exf && !(avs_write && st_ff.busy && ctrlHit)
      |=> st_ff.exf || (irqAck && irqVector == 10'h004);
  endproperty
  a_ext_flag_holds: assert property (p_ext_flag_holds) else $error("flag dropped");

  property p_call_full;
    @(posedge core_clk) disable iff (!nrst)
    subCall && stackFull |=> stackFull && st_ff.stk0 == $past(pcValue);
  endproperty
  a_call_full: assert property (p_call_full) else $error("overflow call wrong");
endmodule : tsic_irq_ctrl

// >>> src/tsic_pkg.sv
// Purpose: Constants and types for the two-source interrupt controller
// Assumes: 25 MHz core_clk, Avalon-MM register access
// Notes: Register map, vectors and state encoding below
package tsic_pkg;
  localparam logic [7:0] TSIC_CTRL_OFS = 8'h0B;
  localparam logic [7:0] TSIC_STAT_OFS = 8'h0C;
  localparam int TSIC_BIT_GIE = 0;
  localparam int TSIC_BIT_EIE = 1;
  localparam int TSIC_BIT_TIE = 2;
  localparam int TSIC_BIT_EXF = 4;
  localparam int TSIC_BIT_TMF = 5;
  localparam logic [7:0] TSIC_CTRL_MASK = 8'h37;
  localparam logic [7:0] TSIC_CTRL_RST = 8'h00;
  localparam logic [9:0] TSIC_VEC_EXT = 10'h004;
  localparam logic [9:0] TSIC_VEC_TMR = 10'h008;
  localparam int TSIC_STACK_DEPTH = 2;
  localparam logic [1:0] TSIC_SP_RST = 2'h0;

  typedef enum logic [1:0]
  {
    TSIC_IDLE = 2'b00,
    TSIC_HALT = 2'b01,
    TSIC_ACK = 2'b10
  } tsic_state_t;
endpackage : tsic_pkg

// >>> src/tsic_sync_if.sv
// Purpose: Carries the synchronised external request pin between modules
// Assumes: Same clock on both sides
// Notes: Level plus falling-edge pulse
interface tsic_sync_if;
  logic pinLevel;
  logic fallPulse;
  modport src (output pinLevel, output fallPulse);
  modport dst (input pinLevel, input fallPulse);
endinterface : tsic_sync_if

// >>> src/tsic_pin_sync.sv
// Purpose: Two-stage synchroniser and falling-edge detector for the request pin
// Assumes: Pin is asynchronous to core_clk
// Notes: Edge is taken from stage two and a third flop only
module tsic_pin_sync
  import tsic_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pin
  input wire logic extIrq_n,
  // To core
  tsic_sync_if.src sync
);
  typedef struct packed
  {
    logic s1;
    logic s2;
    logic s3;
  } tsic_sync_st_t;

  tsic_sync_st_t st_ff;
  tsic_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = extIrq_n;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      // Idle high so release does not fake an edge
      st_ff <= 3'b111;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign sync.pinLevel = st_ff.s2;
  assign sync.fallPulse = st_ff.s3 & ~st_ff.s2;
endmodule : tsic_pin_sync

// >>> verification/tsic_core_model.sv
// Purpose: Core sequencer stand-in for the interrupt controller
// Assumes: Bench requests strobes one cycle wide
// Notes: Phase-two pulse every fourth cycle, free running like the core
module tsic_core_model
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bench requests
  input wire logic [4:0] evReq,
  // To controller
  output logic phaseTwoPulse,
  output logic [4:0] evOut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] divCnt_ff;
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      divCnt_ff <= 2'h0;
    else
      divCnt_ff <= divCnt_ff + 2'h1;
  end
  assign phaseTwoPulse = (divCnt_ff == 2'h3);
  assign evOut = evReq;
endmodule : tsic_core_model

// >>> verification/tsic_irq_ctrl_tb_top.sv
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Avalon-MM access, 25 MHz core_clk
// Notes: Strobe bits 0 ovf, 1 call, 2 return, 3 reenable exit, 4 halt
module tsic_irq_ctrl_tb_top
  import tsic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, avsRead, avsWrite, avsWaitrequest, extIrq_n;
  logic [7:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, rq;
  logic [4:0] evReq, ev;
  logic phaseTwoPulse, irqAck, wakeUp, stackFull;
  logic [9:0] irqVector, returnAddr, lastVec, pc;
  int mismatches, num_checks, ackCnt, wakeCnt, w0;
  tsic_core_model u_tsic_core_model (.core_clk(core_clk), .nrst(nrst), .evReq(evReq),
    .phaseTwoPulse(phaseTwoPulse), .evOut(ev));
  tsic_irq_ctrl u_tsic_irq_ctrl (.core_clk(core_clk), .nrst(nrst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWritedata),
    .avs_byteenable(4'hF), .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest),
    .extIrq_n(extIrq_n), .timerOverflow(ev[0]), .phaseTwoPulse(phaseTwoPulse),
    .subCall(ev[1]), .subroutineExit(ev[2]), .irqExitReenable(ev[3]), .haltEnter(ev[4]),
    .pcValue(pc), .irqAck(irqAck), .irqVector(irqVector), .returnAddr(returnAddr),
    .wakeUp(wakeUp), .stackFull(stackFull));
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // Pulses are one cycle wide, so count them here
  always @(posedge core_clk)
  begin
    if (irqAck === 1'b1)
    begin
      ackCnt++;
      lastVec = irqVector;
    end
    if (wakeUp === 1'b1)
      wakeCnt++;
  end
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  task automatic bail(input string what);
    mismatches++;
    $display("MISMATCH t=%0t %s timed out", $time, what);
    conclude();
  endtask : bail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= d;
    for (n = 0; n < 50; n++)
    begin
      @(posedge core_clk);
      if (avsWaitrequest === 1'b0)
        break;
    end
    rq = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    if (n == 50)
      bail("bus");
  endtask : acc
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    acc(1'b0, a, 32'h0);
    chk(rq, exp, what);
  endtask : rchk
  task automatic pulse(input int i);
    @(posedge core_clk);
    evReq[i] <= 1'b1;
    @(posedge core_clk);
    evReq[i] <= 1'b0;
  endtask : pulse
  // Flag lands three cycles after the edge; sixteen leaves margin
  task automatic pinFall();
    @(posedge core_clk);
    extIrq_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    extIrq_n <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask : pinFall
  task automatic waitAck(input logic [9:0] vec);
    int c0;
    int n;
    c0 = ackCnt;
    for (n = 0; n < 60 && ackCnt == c0; n++)
      @(posedge core_clk);
    if (ackCnt == c0)
      bail("ack");
    chk({22'h0, lastVec}, {22'h0, vec}, "vector");
  endtask : waitAck
  task automatic quiet();
    int c0;
    c0 = ackCnt;
    repeat (24) @(posedge core_clk);
    chk(ackCnt - c0, 32'h0, "stray ack");
  endtask : quiet
  initial
  begin
    nrst = 1'b0;
    extIrq_n = 1'b1;
    evReq = 5'h00;
    pc = 10'h155;
    avsRead = 1'b0;
    avsWrite = 1'b0;
    avsAddress = 8'h00;
    avsWritedata = 32'h0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rchk(TSIC_CTRL_OFS, 32'h00, "reset");
    acc(1'b1, TSIC_CTRL_OFS, 32'hC8);
    rchk(TSIC_CTRL_OFS, 32'h00, "unused bits");
    acc(1'b1, TSIC_CTRL_OFS, 32'h07);
    rchk(TSIC_CTRL_OFS, 32'h07, "enables");
    acc(1'b1, 8'h10, 32'hFF);
    rchk(8'h10, 32'h00, "unmapped");
    acc(1'b1, TSIC_CTRL_OFS, 32'h00);
    $display("test registers done");
    pinFall();
    rchk(TSIC_CTRL_OFS, 32'h10, "ext flag");
    pulse(0);
    rchk(TSIC_CTRL_OFS, 32'h30, "timer flag");
    quiet();
    rchk(TSIC_CTRL_OFS, 32'h30, "flags kept");
    $display("test flags done");
    acc(1'b1, TSIC_CTRL_OFS, 32'h37);
    waitAck(TSIC_VEC_EXT);
    rchk(TSIC_CTRL_OFS, 32'h26, "ext taken");
    quiet();
    pc <= 10'h2A3;
    acc(1'b1, TSIC_CTRL_OFS, 32'h27);
    waitAck(TSIC_VEC_TMR);
    rchk(TSIC_CTRL_OFS, 32'h06, "timer taken");
    rchk(TSIC_STAT_OFS, 32'h06, "stack two");
    chk({31'h0, stackFull}, 32'h1, "full flag");
    pc <= 10'h3C5;
    $display("test service done");
    pulse(0);
    rchk(TSIC_CTRL_OFS, 32'h26, "flag while blocked");
    acc(1'b1, TSIC_CTRL_OFS, 32'h27);
    quiet();
    pulse(2);
    @(posedge core_clk);
    chk({22'h0, returnAddr}, 32'h2A3, "return address");
    waitAck(TSIC_VEC_TMR);
    pulse(3);
    rchk(TSIC_CTRL_OFS, 32'h07, "reenable");
    rchk(TSIC_STAT_OFS, 32'h01, "stack one");
    chk({31'h0, stackFull}, 32'h0, "not full");
    chk({22'h0, returnAddr}, 32'h3C5, "reenable address");
    $display("test full stack done");
    pulse(2);
    acc(1'b1, TSIC_CTRL_OFS, 32'h20);
    pulse(4);
    w0 = wakeCnt;
    pulse(0);
    repeat (8) @(posedge core_clk);
    chk(wakeCnt - w0, 32'h0, "wake on old flag");
    pinFall();
    chk(wakeCnt - w0, 32'h1, "wake on pin");
    chk({22'h0, returnAddr}, 32'h155, "first entry");
    $display("test halt done");
    pc <= 10'h101;
    pulse(1);
    pc <= 10'h102;
    pulse(1);
    pc <= 10'h103;
    pulse(1);
    rchk(TSIC_STAT_OFS, 32'h06, "calls fill stack");
    pulse(2);
    rchk(TSIC_CTRL_OFS, 32'h30, "plain return keeps enable");
    pulse(2);
    @(posedge core_clk);
    chk({22'h0, returnAddr}, 32'h102, "oldest entry lost");
    $display("test calls done");
    conclude();
  end
endmodule : tsic_irq_ctrl_tb_top
